// ---- inc/sdpr_pkg.sv ----
// Package: command encodings, bank geometry and timing constants
package sdpr_pkg;
   // Command field {chip select, row, column, write strobe}, active low
   localparam logic [3:0] CMD_ACTIVATE  = 4'h3;  // LLHH
   localparam logic [3:0] CMD_PRECHARGE = 4'h2;  // LLHL
   localparam logic [3:0] CMD_READ      = 4'h5;  // LHLH
   localparam logic [3:0] CMD_WRITE     = 4'h4;  // LHLL
   localparam logic [3:0] CMD_MODE_SET  = 4'h0;  // LLLL
   localparam logic [3:0] CMD_REFRESH   = 4'h1;  // LLLH
   localparam logic [3:0] CMD_NOP       = 4'h7;  // LHHH
   localparam int         NUM_BANKS     = 8;
   localparam int         BANK_BITS     = 3;
   localparam int         ROW_BITS      = 14;
   localparam int         CMD_BITS      = 4;
   // Timing: clock and row close time in ns
   localparam int         CLK_PERIOD_NS = 10;
   localparam int         ROW_CLOSE_NS  = 15;
   // Close complete after row close time plus one clock, rounded up
   localparam int         CLOSE_CYCLES  = (ROW_CLOSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   localparam int         CNT_BITS      = 4;
   localparam logic [ROW_BITS-1:0] REFRESH_ROW_RESET = 14'h0000;
   localparam logic [BANK_BITS-1:0] REFRESH_BANK_RESET = 3'h0;
   // Power-down kinds
   typedef enum logic [1:0] {SDPR_PD_NONE, SDPR_PD_PRECHARGE, SDPR_PD_ACTIVE_SLOW,
                             SDPR_PD_ACTIVE_FAST} sdpr_pd_type;
endpackage : sdpr_pkg

// ---- rtl/sdpr_core.sv ----
// Device command decode, bank state, refresh counter and power-down control

// Pin path: two synchroniser stages, then decode, then output flops
// Total latency from a sampled pin edge to an output: three clocks
// Ordinary commands count only with the gate high on two samples
// Commands during power-down are dropped without any flag
// Spacing between commands is the controller's duty, not checked here
// Autoclose timing ignores latencies, counts half a burst only
// Close period per bank restarts on every fresh precharge
// Refresh counter steps bank first, then row
// Loop and buffer flags are status only, no analog behaviour
// Low clock enable freezes every flop, synchronisers included

module sdpr_core #(
   parameter int NUM_BANKS = sdpr_pkg::NUM_BANKS,
   parameter int BURST_LEN = 4
) (
   input  wire logic                              mclk,
   input  wire logic                              reset,
   input  wire logic                              clk_en,
   input  wire logic                              chip_sel_n,
   input  wire logic                              row_strobe_n,
   input  wire logic                              col_strobe_n,
   input  wire logic                              write_strobe_n,
   input  wire logic                              clock_gate,
   input  wire logic                              autoclose_addr_bit,
   input  wire logic [sdpr_pkg::BANK_BITS-1:0]    bank_sel,
   input  wire logic                              fast_exit,
   output logic      [NUM_BANKS-1:0]              bank_open,
   output logic      [NUM_BANKS-1:0]              bank_closing,
   output logic                                   refresh_start,
   output logic      [sdpr_pkg::BANK_BITS-1:0]    refresh_bank,
   output logic      [sdpr_pkg::ROW_BITS-1:0]     refresh_row,
   output logic                                   power_down,
   output logic                                   active_power_down,
   output logic                                   buffers_on,
   output logic                                   dll_on,
   output logic                                   mode_set_seen
);
   // Two-flop synchronisers for the pin inputs
   // Only the second stage feeds logic, avoiding metastable reads
   // Reset clears both stages; gate history masks the zero command
   // Width: four strobes, gate, autoclose bit, bank select
   localparam int SW = 6 + sdpr_pkg::BANK_BITS;
   logic [SW-1:0] sync1;
   logic [SW-1:0] sync2;
   always_ff @(posedge mclk) begin
      if (reset) begin
         sync1 <= '0;
         sync2 <= '0;
      end else if (clk_en) begin
         sync1 <= {chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n, clock_gate,
                   autoclose_addr_bit, bank_sel};
         sync2 <= sync1;
      end
   end

   // Decoded inputs
   logic [3:0]                       cmd;
   logic                             gate_now;
   logic                             gate_prev;
   logic                             ac_bit;
   logic [sdpr_pkg::BANK_BITS-1:0]   bank_s;
   logic                             is_nop;
   logic                             cmd_valid;
   assign cmd      = sync2[SW-1:SW-4];
   assign gate_now = sync2[SW-5];
   assign ac_bit   = sync2[SW-6];
   assign bank_s   = sync2[sdpr_pkg::BANK_BITS-1:0];
   // Field slices of the second synchroniser stage
   // Top four bits: chip select, row, column, write strobe
   // Deselect or no-operation
   assign is_nop    = cmd[3] || (cmd == sdpr_pkg::CMD_NOP);
   // Ordinary commands need the gate high on both edges
   assign cmd_valid = gate_prev && gate_now && !power_down && !cmd[3];

   // Previous clock gate sample
   always_ff @(posedge mclk) begin
      if (reset) begin
         gate_prev <= 1'b0;
      end else if (clk_en) begin
         gate_prev <= gate_now;
      end
   end

   // Per-bank open state and close timer
   // One copy per bank; all-bank precharge hits every copy
   // Autoclose counter runs only while armed
   // Close counter loads on precharge or autoclose expiry
   genvar b;
   generate
      for (b = 0; b < NUM_BANKS; b++) begin : g_bank
         logic [sdpr_pkg::CNT_BITS-1:0] close_cnt;
         logic [sdpr_pkg::CNT_BITS-1:0] ac_cnt;
         logic                          ac_pend;
         logic                          hit;
         logic                          pre_hit;
         assign hit     = (bank_s == sdpr_pkg::BANK_BITS'(b));
         // All-bank when bit high, else chosen bank only
         assign pre_hit = cmd_valid && (cmd == sdpr_pkg::CMD_PRECHARGE)
                          && (ac_bit || hit);
         always_ff @(posedge mclk) begin
            if (reset) begin
               bank_open[b]    <= 1'b0;
               bank_closing[b] <= 1'b0;
               close_cnt       <= '0;
               ac_pend         <= 1'b0;
               ac_cnt          <= '0;
            end else if (clk_en) begin
               if (cmd_valid && cmd == sdpr_pkg::CMD_ACTIVATE && hit) begin
                  bank_open[b] <= 1'b1;
               end
               // Autoclose armed by read or write with bit high
               if (cmd_valid && (cmd == sdpr_pkg::CMD_READ || cmd == sdpr_pkg::CMD_WRITE)
                   && hit && ac_bit) begin
                  ac_pend <= 1'b1;
                  ac_cnt  <= sdpr_pkg::CNT_BITS'(BURST_LEN / 2);
               end else if (ac_pend && ac_cnt != '0) begin
                  ac_cnt <= ac_cnt - 1'b1;
               end
               // Close restarts from most recent precharge
               if (pre_hit || (ac_pend && ac_cnt == '0)) begin
                  bank_open[b]    <= 1'b0;
                  bank_closing[b] <= 1'b1;
                  close_cnt       <= sdpr_pkg::CNT_BITS'(sdpr_pkg::CLOSE_CYCLES - 1);
                  if (!pre_hit || ac_pend) begin
                     ac_pend <= 1'b0;
                  end
               end else if (bank_closing[b]) begin
                  if (close_cnt == '0) begin
                     bank_closing[b] <= 1'b0;
                  end else begin
                     close_cnt <= close_cnt - 1'b1;
                  end
               end
            end
         end
      end
   endgenerate

   // Refresh start and internal address counter
   // Pulse lasts one clock per accepted refresh command
   // Counter wraps silently after the last row of the last bank
   always_ff @(posedge mclk) begin
      if (reset) begin
         refresh_start <= 1'b0;
         refresh_bank  <= sdpr_pkg::REFRESH_BANK_RESET;
         refresh_row   <= sdpr_pkg::REFRESH_ROW_RESET;
      end else if (clk_en) begin
         refresh_start <= cmd_valid && (cmd == sdpr_pkg::CMD_REFRESH);
         if (cmd_valid && cmd == sdpr_pkg::CMD_REFRESH) begin
            // Address pins unused; counter supplies location
            {refresh_row, refresh_bank} <= {refresh_row, refresh_bank} + 1'b1;
         end
      end
   end

   // Power-down entry and exit
   // Entry: gate falls between samples with an idle command
   // Exit: gate rises between samples with an idle command
   // Kind fixed at entry from the bank state of that clock
   // Fast exit keeps the loop on only in active power-down
   always_ff @(posedge mclk) begin
      if (reset) begin
         power_down        <= 1'b0;
         active_power_down <= 1'b0;
         buffers_on        <= 1'b1;
         dll_on            <= 1'b1;
      end else if (clk_en) begin
         if (!power_down && gate_prev && !gate_now && is_nop) begin
            power_down        <= 1'b1;
            active_power_down <= |bank_open;
            buffers_on        <= 1'b0;
            dll_on            <= (|bank_open) && fast_exit;
         end else if (power_down && !gate_prev && gate_now && is_nop) begin
            power_down        <= 1'b0;
            active_power_down <= 1'b0;
            buffers_on        <= 1'b1;
            dll_on            <= 1'b1;
         end
      end
   end

   // Mode set command observed
   // Single-cycle pulse, no mode register contents kept
   always_ff @(posedge mclk) begin
      if (reset) begin
         mode_set_seen <= 1'b0;
      end else if (clk_en) begin
         mode_set_seen <= cmd_valid && (cmd == sdpr_pkg::CMD_MODE_SET);
      end
   end
endmodule : sdpr_core

// ---- verif/sdpr_ctrl_model.sv ----
// Memory controller model: drives the command pins from bench requests
module sdpr_ctrl_model (
   input  wire logic       mclk,
   input  wire logic [3:0] req_cmd,
   input  wire logic       req_gate,
   input  wire logic       req_a10,
   input  wire logic [2:0] req_bank,
   output logic            chip_sel_n = 1'b1,
   output logic            row_strobe_n = 1'b1,
   output logic            col_strobe_n = 1'b1,
   output logic            write_strobe_n = 1'b1,
   output logic            clock_gate = 1'b1,
   output logic            autoclose_addr_bit = 1'b0,
   output logic [2:0]      bank_sel = 3'h0
);
   timeunit 1ns;
   timeprecision 1ns;
   // Whole command launched just after each rising edge
   always @(posedge mclk) begin
      {chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n} <= req_cmd;
      {clock_gate, autoclose_addr_bit, bank_sel} <= {req_gate, req_a10, req_bank};
   end
endmodule : sdpr_ctrl_model

// ---- verif/sdpr_core_assertions.sv ----
// Checker for command decode, refresh counter and power-down flags
module sdpr_core_assertions #(parameter int NUM_BANKS = 8) (
   input wire logic                 mclk,
   input wire logic                 reset,
   input wire logic                 chip_sel_n,
   input wire logic                 row_strobe_n,
   input wire logic                 col_strobe_n,
   input wire logic                 write_strobe_n,
   input wire logic                 clock_gate,
   input wire logic                 fast_exit,
   input wire logic [NUM_BANKS-1:0] bank_open,
   input wire logic [NUM_BANKS-1:0] bank_closing,
   input wire logic                 refresh_start,
   input wire logic [2:0]           refresh_bank,
   input wire logic [13:0]          refresh_row,
   input wire logic                 power_down,
   input wire logic                 active_power_down,
   input wire logic                 buffers_on,
   input wire logic                 dll_on
);
   wire [3:0]  cmd = {chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n};
   wire [16:0] cnt = {refresh_row, refresh_bank};
   wire        idle_cmd = chip_sel_n || (cmd == sdpr_pkg::CMD_NOP);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   a_refresh_cause: assert property (refresh_start |-> $past(cmd, 3) == sdpr_pkg::CMD_REFRESH)
      else $error("refresh pulse without refresh command");
   a_counter_step: assert property (refresh_start |-> cnt == $past(cnt) + 17'h00001)
      else $error("refresh counter did not step");
   a_pd_entry: assert property ($rose(power_down) |-> $past(!clock_gate && idle_cmd, 3))
      else $error("power-down entered without gate low and idle command");
   a_pd_exit: assert property ($fell(power_down) |-> $past(clock_gate && idle_cmd, 3))
      else $error("power-down left without gate high and idle command");
   a_pd_kind: assert property ($rose(power_down) |-> active_power_down == |$past(bank_open))
      else $error("wrong power-down kind");
   a_buffers_off: assert property (buffers_on != power_down)
      else $error("buffers not matching power-down state");
   a_dll_off: assert property (power_down && !(active_power_down && fast_exit) |-> !dll_on)
      else $error("delay loop left running in power-down");
   a_close_length: assert property ($rose(bank_closing[0]) |-> bank_closing[0] [*3] ##1 !bank_closing[0])
      else $error("close period of wrong length");
   c_refresh: cover property (refresh_start);
   c_active_pd: cover property ($rose(active_power_down));
   c_close: cover property ($rose(bank_closing[0]));
endmodule : sdpr_core_assertions
bind sdpr_core sdpr_core_assertions #(.NUM_BANKS(NUM_BANKS)) chk_u (.mclk, .reset, .chip_sel_n,
   .row_strobe_n, .col_strobe_n, .write_strobe_n, .clock_gate, .fast_exit, .bank_open,
   .bank_closing, .refresh_start, .refresh_bank, .refresh_row, .power_down,
   .active_power_down, .buffers_on, .dll_on);

// ---- verif/test_sdpr_core.sv ----
// Self-checking bench: bank close, autoclose, refresh and power-down
module test_sdpr_core;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [3:0] NOP = sdpr_pkg::CMD_NOP, ACT = sdpr_pkg::CMD_ACTIVATE;
   localparam logic [3:0] PRE = sdpr_pkg::CMD_PRECHARGE, RD = sdpr_pkg::CMD_READ;
   localparam logic [3:0] WR = sdpr_pkg::CMD_WRITE, RFSH = sdpr_pkg::CMD_REFRESH;
   logic       mclk = 1'b0, reset = 1'b1, clk_en = 1'b1, fast_exit = 1'b0;
   logic       q_gate = 1'b1, q_a10 = 1'b0;
   logic [3:0] q_cmd = NOP;
   logic [2:0] q_bank = 3'h0;
   wire        chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n, clock_gate;
   wire        autoclose_addr_bit, refresh_start, power_down, active_power_down;
   wire        buffers_on, dll_on, mode_set_seen;
   wire [2:0]  bank_sel, refresh_bank;
   wire [7:0]  bank_open, bank_closing;
   wire [13:0] refresh_row;
   int         n_errors = 0, total_checks = 0, cycles = 0, n_ms = 0, n_rf = 0;
   always #5 mclk = ~mclk;
   sdpr_ctrl_model ctl_u (.mclk, .req_cmd(q_cmd), .req_gate(q_gate), .req_a10(q_a10),
      .req_bank(q_bank), .chip_sel_n, .row_strobe_n, .col_strobe_n, .write_strobe_n,
      .clock_gate, .autoclose_addr_bit, .bank_sel);
   sdpr_core dut_u (.mclk, .reset, .clk_en, .chip_sel_n, .row_strobe_n, .col_strobe_n,
      .write_strobe_n, .clock_gate, .autoclose_addr_bit, .bank_sel, .fast_exit, .bank_open,
      .bank_closing, .refresh_start, .refresh_bank, .refresh_row, .power_down,
      .active_power_down, .buffers_on, .dll_on, .mode_set_seen);
   // Pulse counters and hang guard
   always @(posedge mclk) begin
      cycles++;
      if (mode_set_seen === 1'b1) n_ms++;
      if (refresh_start === 1'b1) n_rf++;
      if (cycles == 2000) begin
         n_errors++;
         wrap_up();
      end
   end
   task automatic chk(string nm, logic [16:0] seen, logic [16:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // One request, a no-operation, then n settling edges
   // Waits keep spacing
   task automatic go(logic [3:0] c, logic a10, logic [2:0] b, logic g, int n);
      @(posedge mclk);
      {q_cmd, q_a10, q_bank, q_gate} <= {c, a10, b, g};
      @(posedge mclk);
      q_cmd <= NOP;
      repeat (n) @(posedge mclk);
      #1;
   endtask : go
   // Single-bank and all-bank close with close period
   task automatic t_close();
      go(ACT, 1'b0, 3'h2, 1'b1, 4);
      chk("open", bank_open, 8'h04);
      go(PRE, 1'b0, 3'h2, 1'b1, 4);
      chk("open", bank_open, 8'h00);
      chk("closing", bank_closing, 8'h04);
      go(NOP, 1'b0, 3'h0, 1'b1, 1);
      chk("closing", bank_closing, 8'h00);
      go(ACT, 1'b0, 3'h1, 1'b1, 0);
      go(ACT, 1'b0, 3'h5, 1'b1, 4);
      chk("open", bank_open, 8'h22);
      go(PRE, 1'b1, 3'h1, 1'b1, 4);
      chk("open", bank_open, 8'h00);
      chk("closing", bank_closing, 8'hFF);
   endtask : t_close
   // Autoclose after read and write, plain write keeps the row
   task automatic t_auto();
      go(ACT, 1'b0, 3'h3, 1'b1, 4);
      go(RD, 1'b1, 3'h3, 1'b1, 8);
      chk("open", bank_open, 8'h00);
      go(ACT, 1'b0, 3'h6, 1'b1, 4);
      go(WR, 1'b0, 3'h6, 1'b1, 8);
      chk("open", bank_open, 8'h40);
      go(WR, 1'b1, 3'h6, 1'b1, 8);
      chk("open", bank_open, 8'h00);
   endtask : t_auto
   // Refreshes on idle banks with differing address pins
   task automatic t_refresh();
      go(RFSH, 1'b1, 3'h7, 1'b1, 4);
      go(RFSH, 1'b0, 3'h5, 1'b1, 4);
      chk("refreshes", n_rf, 17'h00002);
      chk("counter", {refresh_row, refresh_bank}, 17'h00002);
      @(posedge mclk) clk_en <= 1'b0;
      go(RFSH, 1'b0, 3'h0, 1'b1, 4);
      chk("frozen refreshes", n_rf, 17'h00002);
      @(posedge mclk) clk_en <= 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      chk("frozen counter", {refresh_row, refresh_bank}, 17'h00002);
   endtask : t_refresh
   // Precharge then active power-down, brief stays
   // Mode set after exit gives one pulse that the bench counts
   task automatic t_pd();
      go(NOP, 1'b0, 3'h0, 1'b0, 4);
      chk("flags", {power_down, active_power_down, buffers_on, dll_on}, 4'h8);
      go(ACT, 1'b0, 3'h1, 1'b0, 4);
      chk("open", bank_open, 8'h00);
      go(NOP, 1'b0, 3'h0, 1'b1, 4);
      chk("flags", {power_down, active_power_down, buffers_on, dll_on}, 4'h3);
      go(ACT, 1'b0, 3'h4, 1'b1, 4);
      @(posedge mclk) fast_exit <= 1'b1;
      go(NOP, 1'b0, 3'h0, 1'b0, 4);
      chk("flags", {power_down, active_power_down, buffers_on, dll_on}, 4'hD);
      go(NOP, 1'b0, 3'h0, 1'b1, 4);
      go(sdpr_pkg::CMD_MODE_SET, 1'b0, 3'h0, 1'b1, 4);
      chk("mode sets", n_ms, 17'h00001);
   endtask : t_pd
   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : wrap_up
   // Reset, then the scenarios in turn
   initial begin
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      t_close();
      t_auto();
      t_refresh();
      t_pd();
      wrap_up();
   end
endmodule : test_sdpr_core
